// *** verilog/rcs_pkg.sv ***
// Constants and types for the calendar clock with alarms and supervisor
//
// Operation
// - In frequency mode the shared pin gives 1 Hz, 4096 Hz, 32768 Hz.
// - Frequency-out control bits choose alarm interrupt or clock output on the pin.
// - In interrupt mode the pin signals an alarm as open-drain active low.
// - After supply recovers, reset output stays asserted 250 ms before release.
// - Reset output asserts whenever supply drops below the selected threshold.
// - A three-bit setting picks one of five supervisor thresholds.
// - Watchdog offers 0.25 s, 0.75 s, 1.75 s timeouts or disabled.
// - An expired watchdog asserts the reset output.
// - Serial bus is ignored during reset unless a config bit allows it.
// - Two alarms match programmable time fields; flag is pollable or drives the pin.
// - Alarms may repeat, giving periodic interrupts.
// - Calendar handles leap years automatically through year 2099.
// - Date rolls over for short months; a bit selects 24-hour or AM/PM.
// - After total power loss counters stay stopped until a clock byte is written.
// - Host reads clock sequentially; the device auto-increments the address.
// - Counters are copied to a latch at the ack before read data; read uses it.
// - Alarm matches during a clock read are still detected and flagged.
// - Each written time byte goes to a staging buffer at its ack, not counters.
// - Stop after a valid write loads staged time; invalid writes discard it.
// - New time appears at the next second tick; counting continues meanwhile.
// - Clock space reached by dedicated slave byte and address 0000h to 003Fh.
// - Status read clears alarm flags set at read start, at last data bit.
package rcs_pkg;
   localparam int REF_HZ = 125_000_000;
   localparam int POR_MS = 250;
   localparam int POR_CYC = POR_MS * (REF_HZ / 1000);
   localparam int XDIV_W = 15;
   localparam int HZ1_BIT = 14;
   localparam int HZ4_BIT = 12;
   localparam int F4096_BIT = 2;
   // Watchdog limits counted in quarter seconds
   localparam logic [2:0] WDT_Q_SHORT = 3'h1;
   localparam logic [2:0] WDT_Q_MID = 3'h3;
   localparam logic [2:0] WDT_Q_LONG = 3'h7;
   localparam logic [1:0] WDT_OFF = 2'h0;
   localparam logic [1:0] WDT_SHORT = 2'h1;
   localparam logic [1:0] WDT_MID = 2'h2;
   localparam logic [1:0] WDT_LONG = 2'h3;
   localparam int NUM_LEVELS = 5;
   localparam logic [2:0] THR_MAX = 3'h4;
   // Slave identity, value arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h2a;
   localparam logic [5:0] A_SR = 6'h3f;
   localparam logic [2:0] SEC_ALM0 = 3'h0;
   localparam logic [2:0] SEC_ALM1 = 3'h1;
   localparam logic [2:0] SEC_RTC = 3'h6;
   localparam logic [7:0] SR_CLR = 8'h00;
   localparam logic [7:0] SR_SET_WEL = 8'h02;
   localparam logic [7:0] SR_SET_REGISTER_WRITE_LATCH = 8'h06;
   localparam logic [1:0] FO_IRQ = 2'h0;
   localparam logic [1:0] FO_1HZ = 2'h1;
   localparam logic [1:0] FO_4096 = 2'h2;
   localparam logic [1:0] FO_32K = 2'h3;

   typedef struct packed {
      logic [7:0] y2k;
      logic [7:0] dow;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } rcs_time_t;

   localparam rcs_time_t TIME_RST = '{8'h20, 8'h00, 8'h00, 8'h01, 8'h01, 8'h12, 8'h00, 8'h00};

   typedef struct packed {
      logic o;
      logic oe;
   } rcs_od_t;

   typedef struct packed {
      logic [1:0] fo_sel;
      logic [1:0] irq_en;
      logic [1:0] alarm_repeat;
      logic [2:0] thr_sel;
      logic [1:0] wdt_sel;
      logic bus_in_reset_en;
   } rcs_cfg_t;

   typedef enum logic [5:0] {
      I_IDLE = 6'h01,
      I_DEV = 6'h02,
      I_AHI = 6'h04,
      I_ALO = 6'h08,
      I_WR = 6'h10,
      I_RD = 6'h20
   } rcs_i2c_t;
endpackage

// *** verilog/rcs_core.sv ***
// Calendar clock core with alarms, clock output, supervisor and serial slave
`timescale 1ns/10ps
module rcs_core #(
   parameter int POR_CYCLES = rcs_pkg::POR_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic xtal_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [rcs_pkg::NUM_LEVELS-1:0] supply_below,
   input wire logic on_battery,
   input wire logic osc_fail,
   input wire rcs_pkg::rcs_cfg_t cfg,
   output rcs_pkg::rcs_od_t sda_pin,
   output rcs_pkg::rcs_od_t alarm_irq_or_clock_out,
   output rcs_pkg::rcs_od_t rst_pin,
   output logic [1:0] alarm_flags,
   output logic clock_running
);
   import rcs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   function automatic logic is_leap(input logic [7:0] y);
      // Every fourth year; correct until the century rollover
      is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
      case (m)
         8'h02: month_len = is_leap(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
         default: month_len = 8'h31;
      endcase
   endfunction

   function automatic rcs_time_t adv(input rcs_time_t t);
      rcs_time_t n;
      logic day;
      logic [7:0] h8;
      n = t;
      day = 1'b0;
      h8 = bcd_inc({3'b000, t.hour[4:0]});
      if (t.sec != 8'h59) begin
         n.sec = bcd_inc(t.sec);
      end else begin
         n.sec = 8'h00;
         if (t.min != 8'h59) begin
            n.min = bcd_inc(t.min);
         end else begin
            n.min = 8'h00;
            if (t.hour[7]) begin
               if (t.hour[5:0] == 6'h23) begin
                  n.hour = 8'h80;
                  day = 1'b1;
               end else begin
                  n.hour = bcd_inc({2'b00, t.hour[5:0]}) | 8'h80;
               end
            end else if (t.hour[4:0] == 5'h12) begin
               n.hour = {t.hour[7:5], 5'h01};
            end else if (t.hour[4:0] == 5'h11) begin
               n.hour = {t.hour[7:6], ~t.hour[5], 5'h12};
               day = t.hour[5];
            end else begin
               n.hour = {t.hour[7:5], h8[4:0]};
            end
         end
      end
      if (day) begin
         n.dow = (t.dow == 8'h06) ? 8'h00 : t.dow + 8'h01;
         if (t.date != month_len(t.month, t.year)) begin
            n.date = bcd_inc(t.date);
         end else begin
            n.date = 8'h01;
            if (t.month != 8'h12) begin
               n.month = bcd_inc(t.month);
            end else begin
               n.month = 8'h01;
               n.year = (t.year == 8'h99) ? 8'h00 : bcd_inc(t.year);
               if (t.year == 8'h99) begin
                  n.y2k = bcd_inc(t.y2k);
               end
            end
         end
      end
      adv = n;
   endfunction

   function automatic logic [5:0] addr_inc(input logic [5:0] a);
      // Wraps inside one eight-byte section
      addr_inc = {a[5:3], a[2:0] + 3'h1};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Crystal domain: free-running divider, reset brought over by two flops
   logic [1:0] xrst_r;
   logic [XDIV_W-1:0] xdiv_r;
   logic xph_r;
   logic xnh_r;

   always_ff @(posedge xtal_clk) begin
      xrst_r <= {xrst_r[0], rstn};
   end

   always_ff @(posedge xtal_clk) begin
      if (!xrst_r[1]) begin
         xdiv_r <= '0;
         xph_r <= 1'b0;
      end else begin
         xdiv_r <= xdiv_r + 1'b1;
         xph_r <= ~xph_r;
      end
   end

   // Follows the positive flop half a period later; the xor rebuilds the crystal rate
   always_ff @(negedge xtal_clk) begin
      xnh_r <= xph_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossings: each divider tap is a level, edges found after the second flop
   logic [3:0] lvl_x;
   logic [3:0] lvl_s1_r;
   logic [3:0] lvl_s2_r;
   logic [3:0] lvl_s3_r;
   logic [8:0] pin_x;
   logic [8:0] pin_s1_r;
   logic [8:0] pin_s2_r;
   logic [8:0] pin_s3_r;

   assign lvl_x = {xdiv_r[HZ1_BIT], xdiv_r[HZ4_BIT], xdiv_r[F4096_BIT], xph_r ^ xnh_r};
   assign pin_x = {osc_fail, on_battery, supply_below, sda_i, scl_i};

   always_ff @(posedge ref_clk) begin
      lvl_s1_r <= lvl_x;
      lvl_s2_r <= lvl_s1_r;
      lvl_s3_r <= lvl_s2_r;
      pin_s1_r <= pin_x;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
   end

   logic sec_tick;
   logic qtr_tick;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;
   logic [NUM_LEVELS-1:0] supply_s;

   assign sec_tick = lvl_s2_r[3] & ~lvl_s3_r[3];
   assign qtr_tick = lvl_s2_r[2] & ~lvl_s3_r[2];
   assign sda_s = pin_s2_r[1];
   assign scl_rise = pin_s2_r[0] & ~pin_s3_r[0];
   assign scl_fall = ~pin_s2_r[0] & pin_s3_r[0];
   assign i2c_start = pin_s2_r[0] & pin_s3_r[0] & pin_s3_r[1] & ~pin_s2_r[1];
   assign i2c_stop = pin_s2_r[0] & pin_s3_r[0] & ~pin_s3_r[1] & pin_s2_r[1];
   assign supply_s = pin_s2_r[6:2];

   ////////////////////////////////////////////////////////////////////////////
   // Supervisor
   logic [2:0] thr_idx;
   logic below;
   logic [31:0] por_cnt_r;
   logic rst_act_r;
   logic [2:0] wdt_q_r;
   logic [2:0] wdt_lim;
   logic wdt_fire;
   logic bus_ok;

   assign thr_idx = (cfg.thr_sel > THR_MAX) ? THR_MAX : cfg.thr_sel;
   assign below = supply_s[thr_idx];
   assign bus_ok = ~rst_act_r | cfg.bus_in_reset_en;

   always_comb begin
      case (cfg.wdt_sel)
         WDT_SHORT: wdt_lim = WDT_Q_SHORT;
         WDT_MID: wdt_lim = WDT_Q_MID;
         WDT_LONG: wdt_lim = WDT_Q_LONG;
         default: wdt_lim = 3'h0;
      endcase
   end

   // First quarter may be partial, so a timeout lands within one quarter short of its limit
   assign wdt_fire = (cfg.wdt_sel != WDT_OFF) && qtr_tick && (wdt_q_r == wdt_lim - 3'h1);

   always_ff @(posedge ref_clk) begin
      if (!rstn || rst_act_r || cfg.wdt_sel == WDT_OFF || (i2c_start && bus_ok)) begin
         wdt_q_r <= 3'h0;
      end else if (qtr_tick) begin
         wdt_q_r <= wdt_q_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rst_act_r <= 1'b1;
         por_cnt_r <= 32'(POR_CYCLES);
      end else if (below || wdt_fire) begin
         rst_act_r <= 1'b1;
         por_cnt_r <= 32'(POR_CYCLES);
      end else if (por_cnt_r != 32'h0000_0000) begin
         por_cnt_r <= por_cnt_r - 32'h0000_0001;
      end else begin
         rst_act_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave
   rcs_i2c_t st_r;
   logic [3:0] bitc_r;
   logic [7:0] sh_r;
   logic rw_r;
   logic mack_r;
   logic sda_oe_r;
   logic [5:0] addr_r;
   logic sr_hit_r;
   logic wel_r;
   logic register_write_latch_r;
   logic [1:0] al_r;
   logic [1:0] al_cap_r;
   logic rd_sr_r;
   rcs_time_t cnt_r;
   rcs_time_t snap_r;
   logic [7:0] alm_r [0:15];
   logic [7:0] rd_data;
   logic [63:0] tsrc;
   logic [7:0] sr_v;
   logic dev_hit;
   logic byte_fall;
   logic ack_fall;
   logic wr_byte;
   logic ld_ev;

   assign dev_hit = (sh_r[7:1] == DEV_ADDR);
   assign byte_fall = scl_fall && bitc_r == 4'h7 && bus_ok;
   assign ack_fall = scl_fall && bitc_r == 4'h8 && bus_ok;
   assign wr_byte = byte_fall && st_r == I_WR && !i2c_start && !i2c_stop;
   assign ld_ev = ack_fall && ((st_r == I_DEV && rw_r && sda_oe_r) || (st_r == I_RD && mack_r));
   assign sr_v = {pin_s2_r[7], al_r, pin_s2_r[8], 1'b0, register_write_latch_r, wel_r, ~clock_running};
   // First byte is served live while the copy is being taken in the same cycle
   assign tsrc = (st_r == I_DEV) ? cnt_r : snap_r;

   always_comb begin
      rd_data = 8'h00;
      if (addr_r[5:4] == 2'b00) begin
         rd_data = alm_r[addr_r[3:0]];
      end else if (addr_r[5:3] == SEC_RTC) begin
         rd_data = tsrc[{addr_r[2:0], 3'b000} +: 8];
      end else if (addr_r == A_SR) begin
         rd_data = sr_v;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn || !bus_ok) begin
         st_r <= I_IDLE;
         bitc_r <= 4'h0;
         sh_r <= 8'h00;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         sda_oe_r <= 1'b0;
         addr_r <= 6'h00;
      end else if (i2c_start) begin
         st_r <= I_DEV;
         // The SCL fall that closes the start wraps this to zero, so it is not a bit
         bitc_r <= 4'hf;
         sda_oe_r <= 1'b0;
      end else if (i2c_stop) begin
         st_r <= I_IDLE;
         sda_oe_r <= 1'b0;
      end else if (st_r != I_IDLE && scl_rise) begin
         if (bitc_r != 4'h8 && st_r != I_RD) begin
            sh_r <= {sh_r[6:0], sda_s};
         end
         if (bitc_r == 4'h8 && st_r == I_RD) begin
            mack_r <= ~sda_s;
         end
      end else if (st_r != I_IDLE && scl_fall) begin
         if (bitc_r == 4'h7) begin
            bitc_r <= 4'h8;
            case (st_r)
               I_DEV: begin
                  sda_oe_r <= dev_hit;
                  rw_r <= sh_r[0];
               end
               I_AHI: sda_oe_r <= (sh_r == 8'h00);
               I_ALO: sda_oe_r <= (sh_r[7:6] == 2'b00);
               I_WR: sda_oe_r <= ~(addr_r == A_SR && sr_hit_r);
               default: sda_oe_r <= 1'b0;
            endcase
         end else if (bitc_r == 4'h8) begin
            bitc_r <= 4'h0;
            sda_oe_r <= 1'b0;
            if (ld_ev) begin
               st_r <= I_RD;
               sh_r <= rd_data;
               sda_oe_r <= ~rd_data[7];
               addr_r <= addr_inc(addr_r);
            end else if (!sda_oe_r) begin
               st_r <= I_IDLE;
            end else begin
               case (st_r)
                  I_DEV: st_r <= I_AHI;
                  I_AHI: st_r <= I_ALO;
                  I_ALO: begin
                     st_r <= I_WR;
                     addr_r <= sh_r[5:0];
                  end
                  I_WR: addr_r <= addr_inc(addr_r);
                  default: st_r <= I_IDLE;
               endcase
            end
         end else begin
            bitc_r <= bitc_r + 4'h1;
            if (st_r == I_RD) begin
               sh_r <= {sh_r[6:0], 1'b0};
               sda_oe_r <= ~sh_r[6];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status latches and snapshot
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wel_r <= 1'b0;
         register_write_latch_r <= 1'b0;
         sr_hit_r <= 1'b0;
      end else if (i2c_start || i2c_stop) begin
         sr_hit_r <= 1'b0;
      end else if (wr_byte && addr_r == A_SR && !sr_hit_r) begin
         sr_hit_r <= 1'b1;
         case (sh_r)
            SR_CLR: begin
               wel_r <= 1'b0;
               register_write_latch_r <= 1'b0;
            end
            SR_SET_WEL: wel_r <= 1'b1;
            SR_SET_REGISTER_WRITE_LATCH: register_write_latch_r <= wel_r;
            default: wel_r <= wel_r;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         snap_r <= TIME_RST;
         rd_sr_r <= 1'b0;
         al_cap_r <= 2'b00;
      end else if (ld_ev) begin
         if (st_r == I_DEV) begin
            snap_r <= cnt_r;
         end
         rd_sr_r <= (addr_r == A_SR);
         al_cap_r <= al_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write staging and commit
   logic [7:0] stg_r [0:7];
   logic [7:0] stg_mask_r;
   logic [2:0] stg_sec_r;
   logic commit_ev;
   rcs_time_t merged;

   assign commit_ev = i2c_stop && st_r == I_WR && (|stg_mask_r) && wel_r && register_write_latch_r && bus_ok;

   always_ff @(posedge ref_clk) begin
      if (!rstn || !bus_ok || i2c_start || i2c_stop) begin
         stg_mask_r <= 8'h00;
         stg_sec_r <= 3'h0;
      end else if (wr_byte && addr_r != A_SR) begin
         stg_r[addr_r[2:0]] <= sh_r;
         stg_mask_r[addr_r[2:0]] <= 1'b1;
         stg_sec_r <= addr_r[5:3];
      end
   end

   always_comb begin
      merged = cnt_r;
      for (int i = 0; i < 8; i++) begin
         if (stg_mask_r[i]) begin
            merged[i*8 +: 8] = stg_r[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time counters
   rcs_time_t pend_r;
   logic pend_v_r;
   logic tick_d_r;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cnt_r <= TIME_RST;
         pend_r <= TIME_RST;
         pend_v_r <= 1'b0;
         clock_running <= 1'b0;
         tick_d_r <= 1'b0;
      end else begin
         tick_d_r <= sec_tick;
         if (sec_tick) begin
            if (pend_v_r) begin
               cnt_r <= pend_r;
               pend_v_r <= 1'b0;
            end else if (clock_running) begin
               cnt_r <= adv(cnt_r);
            end
         end
         if (commit_ev && stg_sec_r == SEC_RTC) begin
            pend_r <= merged;
            pend_v_r <= 1'b1;
            clock_running <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarms
   logic [1:0] al_set;
   logic [1:0] done_r;
   logic [1:0] al_clr;

   assign al_clr = (byte_fall && st_r == I_RD && rd_sr_r) ? al_cap_r : 2'b00;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         for (int i = 0; i < 16; i++) begin
            alm_r[i] <= 8'h00;
         end
      end else if (commit_ev && stg_sec_r[2:1] == 2'b00) begin
         for (int i = 0; i < 8; i++) begin
            if (stg_mask_r[i]) begin
               alm_r[{stg_sec_r[0], 3'(i)}] <= stg_r[i];
            end
         end
      end
   end

   generate
      for (genvar g = 0; g < 2; g++) begin : g_alm
         logic hit;
         logic any;
         logic eq;
         logic [7:0] a;
         always_comb begin
            any = 1'b0;
            eq = 1'b1;
            a = 8'h00;
            for (int k = 0; k < 7; k++) begin
               a = alm_r[g*8 + k];
               if (a[7]) begin
                  any = 1'b1;
                  if (a[6:0] != cnt_r[k*8 +: 7]) begin
                     eq = 1'b0;
                  end
               end
            end
            hit = any & eq;
         end
         // Compared on the live counters, so a read in progress cannot hide a match
         assign al_set[g] = tick_d_r & hit & ~done_r[g];

         always_ff @(posedge ref_clk) begin
            if (!rstn || (commit_ev && stg_sec_r == 3'(g))) begin
               done_r[g] <= 1'b0;
            end else if (al_set[g] && !cfg.alarm_repeat[g]) begin
               done_r[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Set wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         al_r <= 2'b00;
      end else begin
         al_r <= (al_r & ~al_clr) | al_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sda_pin <= '{o: 1'b0, oe: 1'b0};
         rst_pin <= '{o: 1'b0, oe: 1'b1};
         alarm_irq_or_clock_out <= '{o: 1'b0, oe: 1'b0};
         alarm_flags <= 2'b00;
      end else begin
         sda_pin <= '{o: 1'b0, oe: sda_oe_r};
         rst_pin <= '{o: 1'b0, oe: rst_act_r};
         alarm_flags <= al_r;
         case (cfg.fo_sel)
            FO_IRQ: alarm_irq_or_clock_out <= '{o: 1'b0, oe: |(al_r & cfg.irq_en)};
            FO_1HZ: alarm_irq_or_clock_out <= '{o: 1'b0, oe: ~lvl_s2_r[3]};
            FO_4096: alarm_irq_or_clock_out <= '{o: 1'b0, oe: ~lvl_s2_r[1]};
            FO_32K: alarm_irq_or_clock_out <= '{o: 1'b0, oe: ~lvl_s2_r[0]};
            default: alarm_irq_or_clock_out <= '{o: 1'b0, oe: 1'b0};
         endcase
      end
   end
endmodule // rcs_core

// *** test/rcs_core_properties.sv ***
// Port assertions for the calendar clock core
`timescale 1ns/10ps
module rcs_core_chk #(
   parameter int POR_CYCLES = rcs_pkg::POR_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [rcs_pkg::NUM_LEVELS-1:0] supply_below,
   input wire rcs_pkg::rcs_cfg_t cfg,
   input wire rcs_pkg::rcs_od_t sda_pin,
   input wire rcs_pkg::rcs_od_t alarm_irq_or_clock_out,
   input wire rcs_pkg::rcs_od_t rst_pin,
   input wire logic [1:0] alarm_flags,
   input wire logic clock_running
);
   import rcs_pkg::*;
   logic sup_ok;
   // Codes above the top level act as the top level
   assign sup_ok = !supply_below[(cfg.thr_sel > THR_MAX) ? THR_MAX : cfg.thr_sel];
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   chk_reset_state: assert property (
      disable iff (1'b0) !rstn |=> rst_pin.oe && !sda_pin.oe) else $error("bad reset state");
   chk_por_hold: assert property ($rose(rstn) |-> rst_pin.oe [*8])
      else $error("reset output dropped early");
   chk_low_supply: assert property (!sup_ok |-> ##[1:8] rst_pin.oe)
      else $error("low supply not flagged");
   chk_por_release: assert property ($fell(rst_pin.oe) |-> $past(sup_ok, 8))
      else $error("reset released with low supply");
   chk_bus_ignored: assert property (
      (rst_pin.oe && !cfg.bus_in_reset_en) [*8] |-> !sda_pin.oe) else $error("bus used in reset");
   chk_irq_idle: assert property (
      (cfg.fo_sel == FO_IRQ && (alarm_flags & cfg.irq_en) == 2'h0) [*4]
      |-> !alarm_irq_or_clock_out.oe) else $error("pin low without alarm");
   chk_clk_toggle: assert property (
      (cfg.fo_sel == FO_32K) [*8] |->
      alarm_irq_or_clock_out.oe != $past(alarm_irq_or_clock_out.oe, 4))
      else $error("clock output stuck");
   chk_run_kept: assert property (clock_running |=> clock_running)
      else $error("clock stopped");
endmodule // rcs_core_chk
bind rcs_core rcs_core_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rstn(rstn), .supply_below(supply_below), .cfg(cfg), .sda_pin(sda_pin),
   .alarm_irq_or_clock_out(alarm_irq_or_clock_out), .rst_pin(rst_pin),
   .alarm_flags(alarm_flags), .clock_running(clock_running));

// *** test/rcs_i2c_host.sv ***
// Serial bus host model driving the two-wire link
`timescale 1ns/10ps
module rcs_i2c_host (
   input wire logic ref_clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_low
);
   localparam int QTR = 20;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic qtr();
      repeat (QTR) @(negedge ref_clk);
   endtask
   // Also a repeated start, since SCL rests low between bytes
   task automatic start();
      qtr();
      sda_low = 1'b0;
      qtr();
      scl = 1'b1;
      qtr();
      sda_low = 1'b1;
      qtr();
      scl = 1'b0;
   endtask
   task automatic stop();
      qtr();
      sda_low = 1'b1;
      qtr();
      scl = 1'b1;
      qtr();
      sda_low = 1'b0;
   endtask
   // SDA changes only with SCL low; read at mid high phase
   task automatic xbit(input logic b, output logic r);
      qtr();
      sda_low = !b;
      qtr();
      scl = 1'b1;
      qtr();
      r = sda_in;
      qtr();
      scl = 1'b0;
   endtask
   task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(ab, a);
      ack = !a;
   endtask
endmodule // rcs_i2c_host

// *** test/tb.sv ***
// Self-checking bench for the calendar clock core
`timescale 1ns/10ps
module tb;
   import rcs_pkg::*;
   localparam int POR = 6000;
   logic ref_clk, xtal_clk, rstn, on_battery, osc_fail, scl, host_low, sda, ack, clock_running;
   logic [NUM_LEVELS-1:0] supply_below;
   rcs_cfg_t cfg;
   rcs_od_t sda_pin, irq_pin, rst_pin;
   logic [1:0] alarm_flags;
   logic [7:0] exp_q[$];
   logic [7:0] got_v;
   logic [63:0] d;
   int fail_count, n_compared, cyc, cnt, e;
   logic p;
   event got_ev;
   // Pulled up unless some party pulls low
   assign sda = !(host_low || sda_pin.oe);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = !ref_clk;
   end
   initial begin
      xtal_clk = 1'b0;
      #3.3;
      forever #32 xtal_clk = !xtal_clk;
   end
   rcs_core #(.POR_CYCLES(POR)) dut (.ref_clk(ref_clk), .rstn(rstn), .xtal_clk(xtal_clk),
      .scl_i(scl), .sda_i(sda), .supply_below(supply_below), .on_battery(on_battery),
      .osc_fail(osc_fail), .cfg(cfg), .sda_pin(sda_pin), .alarm_irq_or_clock_out(irq_pin),
      .rst_pin(rst_pin), .alarm_flags(alarm_flags), .clock_running(clock_running));
   rcs_i2c_host host (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_low(host_low));
   always @(negedge ref_clk) if (!rstn) cyc = 0; else if (rst_pin.oe) cyc++;
   always @(got_ev) begin
      n_compared++;
      if (got_v !== exp_q[0]) begin
         fail_count++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp_q[0], got_v);
      end
      void'(exp_q.pop_front());
   end
   task automatic note(input logic [7:0] ev, input logic [7:0] g);
      exp_q.push_back(ev);
      got_v = g;
      ->got_ev;
      #1;
   endtask
   task automatic end_sim();
      if (fail_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wait_rel();
      for (int k = 0; rst_pin.oe !== 1'b0; k++) begin
         if (k == 10000) begin
            fail_count++;
            end_sim();
         end
         @(negedge ref_clk);
      end
   endtask
   task automatic wr(input logic [7:0] a, input int n, input logic [63:0] dv, output logic ok,
         input logic fin);
      logic [7:0] rr;
      logic k;
      host.start();
      host.xbyte({DEV_ADDR, 1'b0}, 1'b1, rr, ok);
      host.xbyte(8'h00, 1'b1, rr, k);
      ok = ok & k;
      host.xbyte(a, 1'b1, rr, k);
      ok = ok & k;
      for (int i = 0; i < n; i++) begin
         host.xbyte(dv[8*i +: 8], 1'b1, rr, k);
         ok = ok & k;
      end
      if (fin) host.stop();
   endtask
   task automatic rd(input logic [7:0] a, input int n, input logic [63:0] ev);
      logic [7:0] rr;
      logic k;
      wr(a, 0, 64'h0, k, 1'b0);
      host.start();
      host.xbyte({DEV_ADDR, 1'b1}, 1'b1, rr, k);
      for (int i = 0; i < n; i++) begin
         host.xbyte(8'hff, i == n - 1, rr, k);
         note(ev[8*i +: 8], rr);
      end
      host.stop();
   endtask
   initial begin
      #800_000;
      fail_count++;
      end_sim();
   end
   initial begin
      {fail_count, n_compared, rstn, osc_fail} = '0;
      supply_below = '0;
      on_battery = 1'b1;
      cfg = '{FO_IRQ, 2'h3, 2'h0, 3'h0, WDT_OFF, 1'b0};
      void'($urandom(32'h81a0));
      cfg.thr_sel = 3'($urandom_range(4, 0));
      repeat (5) @(negedge ref_clk);
      rstn = 1'b1;
      wr({2'h0, A_SR}, 1, 64'(SR_SET_WEL), ack, 1'b1);
      note(8'h0, {7'h0, ack});
      wait_rel();
      note(8'h1, {7'h0, cyc >= POR && cyc <= POR + 8});
      supply_below = 5'h01 << ((cfg.thr_sel + 3'h1) % 3'h5);
      repeat (20) @(negedge ref_clk);
      note(8'h0, {7'h0, rst_pin.oe});
      supply_below = 5'h01 << cfg.thr_sel;
      repeat (20) @(negedge ref_clk);
      note(8'h1, {7'h0, rst_pin.oe});
      supply_below = '0;
      cyc = 0;
      wait_rel();
      note(8'h1, {7'h0, cyc >= POR && cyc <= POR + 8});
      // Pin edges in 640 cycles: crystal period is 8 cycles, 4096 Hz tap is 64
      for (int f = 0; f < 4; f++) begin
         cfg.fo_sel = 2'(f);
         repeat (16) @(negedge ref_clk);
         cnt = 0;
         p = irq_pin.oe;
         repeat (640) begin
            @(negedge ref_clk);
            cnt += int'(irq_pin.oe !== p);
            p = irq_pin.oe;
         end
         e = (f == 3) ? 160 : (f == 2) ? 20 : 0;
         note(8'(e), 8'((cnt <= e + 2 && cnt + 2 >= e) ? e : cnt));
      end
      cfg.fo_sel = FO_IRQ;
      rd({2'h0, A_SR}, 1, 64'h81);
      wr({2'h0, A_SR}, 1, 64'(SR_SET_WEL), ack, 1'b1);
      wr({2'h0, A_SR}, 1, 64'(SR_SET_REGISTER_WRITE_LATCH), ack, 1'b1);
      rd({2'h0, A_SR}, 1, 64'h87);
      // Day-of-week compare on 6 never matches; other fields are disabled
      for (int i = 0; i < 6; i++) d[8*i +: 8] = 8'($urandom) & 8'h7f;
      d[63:48] = 16'h0086;
      wr(8'h00, 7, d, ack, 1'b1);
      rd(8'h00, 7, d);
      wr(8'h30, 8, 64'h2003_2402_2893_5958, ack, 1'b1);
      for (int k = 0; k < 100 && clock_running !== 1'b1; k++) @(negedge ref_clk);
      note(8'h1, {7'h0, clock_running});
      rd({2'h0, A_SR}, 1, 64'h86);
      rd(8'h20, 1, 64'h0);
      wr(8'h40, 0, 64'h0, ack, 1'b1);
      note(8'h0, {7'h0, ack});
      note(8'h0, {6'h0, alarm_flags});
      end_sim();
   end
endmodule // tb
